// ==== rtl/ads_defines.vh ====
// constants for the converter serial pin logic
`ifndef ADS_DEFINES_VH
`define ADS_DEFINES_VH
`define ADS_CMD_BITS 8
`define ADS_LEN_8 2'd0
`define ADS_LEN_16 2'd1
`define ADS_LEN_24 2'd2
`define ADS_DAC_FULL 12'hFFF
`define ADS_DAC_ZERO 12'h000
`define ADS_CMD_DAC_NIB 4'h1
`define ADS_CMD_CKMODE_NIB 4'h2
`define ADS_CMD_READ_NIB 4'h3
`define ADS_CKMODE_RISE 2'b11
`define ADS_FIFO_DEPTH 4
`define ADS_FIFO_WIDTH 16
`endif

// ==== rtl/ads_fifo.v ====
// small valid/ready fifo for result words
`timescale 1ns/100ps
module ads_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // system
  input wire clk,
  input wire arst_n,
  // fill side
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // drain side
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_reg;
  reg [AW-1:0] rdPtr_reg;
  reg [AW:0] count_reg;
  wire doWrite;
  wire doRead;

  assign inReady = (count_reg != DEPTH[AW:0]);
  assign outValid = (count_reg != {(AW+1){1'b0}});
  assign outData = mem[rdPtr_reg];
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;

  always @(posedge clk) begin
    if (doWrite) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_reg <= {AW{1'b0}};
      rdPtr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (doWrite) begin
        wrPtr_reg <= (wrPtr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_reg + 1'b1;
      end
      if (doRead) begin
        rdPtr_reg <= (rdPtr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_reg + 1'b1;
      end
      if (doWrite && !doRead) begin
        count_reg <= count_reg + 1'b1;
      end else if (doRead && !doWrite) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// ==== rtl/ads_serial_port.v ====
// serial port, conversion-done and dac load logic of the converter
// Behaviour
// - conversion-done output goes low when a result is ready and data is valid after it falls.
// - in clock modes 00, 01 and 10 each output bit is launched on the serial clock falling edge.
// - in clock mode 11 each output bit is launched on the serial clock rising edge.
// - the serial output is high impedance while chip-select is high.
// - the serial input is captured on each serial clock falling edge up to the last bit of the length set by the command byte.
// - serial clock and input are acted on only while chip-select is low.
// - while the load input is low the dac outputs follow the input registers directly.
// - reset clears each dac input register to 000h; for three clocks after release it loads FFFh if the power-up select is high, else 000h.
// - chip-select high returns the port to idle and drops a partial transfer.
// - the command byte sets a transfer length of 8, 16 or 24 bits and its target.
`timescale 1ns/100ps
`include "ads_defines.vh"
module ads_serial_port #(
  parameter DAC_W = 12,
  parameter NDAC = 4
) (
  // system
  input wire clk,
  input wire arst_n,
  // serial pins
  input wire csN,
  input wire sclk,
  input wire din,
  output reg dout,
  output wire doutOeN,
  output reg eocN,
  // dac controls
  input wire dac_load_n,
  input wire dac_powerup_select,
  output wire [NDAC*DAC_W-1:0] dacOut,
  // conversion results from the converter core
  input wire resultValid,
  output wire resultReady,
  input wire [`ADS_FIFO_WIDTH-1:0] resultData,
  // current clock mode
  output reg [1:0] clockMode
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  reg [1:0] csSync_reg;
  reg [1:0] sclkSync_reg;
  reg [1:0] dinSync_reg;
  reg [1:0] loadSync_reg;
  reg [1:0] selSync_reg;
  reg sclkPrev_reg;
  reg started_reg;
  wire csLow;
  wire sclkFall;
  wire sclkRise;
  wire dinS;
  wire loadLow;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      csSync_reg <= 2'b11;
      sclkSync_reg <= 2'b00;
      dinSync_reg <= 2'b00;
      loadSync_reg <= 2'b11;
      selSync_reg <= 2'b00;
      sclkPrev_reg <= 1'b0;
    end else begin
      csSync_reg <= {csSync_reg[0], csN};
      sclkSync_reg <= {sclkSync_reg[0], sclk};
      dinSync_reg <= {dinSync_reg[0], din};
      loadSync_reg <= {loadSync_reg[0], dac_load_n};
      selSync_reg <= {selSync_reg[0], dac_powerup_select};
      sclkPrev_reg <= sclkSync_reg[1];
    end
  end

  assign csLow = !csSync_reg[1];
  // edges show three clocks after the pin, so each sclk phase needs three clocks
  assign sclkFall = csLow && sclkPrev_reg && !sclkSync_reg[1];
  assign sclkRise = csLow && !sclkPrev_reg && sclkSync_reg[1];
  assign dinS = dinSync_reg[1];
  assign loadLow = !loadSync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // command decode
  function [1:0] cmdLength;
    input [7:0] cmd;
    begin
      case (cmd[7:4])
        `ADS_CMD_DAC_NIB: cmdLength = `ADS_LEN_24;
        `ADS_CMD_READ_NIB: cmdLength = `ADS_LEN_16;
        default: cmdLength = `ADS_LEN_8;
      endcase
    end
  endfunction

  // command class tests shared by the shifter and the read pop logic
  function isDacCmd;
    input [7:0] cmd;
    begin
      isDacCmd = (cmd[7:4] == `ADS_CMD_DAC_NIB);
    end
  endfunction

  function isModeCmd;
    input [7:0] cmd;
    begin
      isModeCmd = (cmd[7:4] == `ADS_CMD_CKMODE_NIB);
    end
  endfunction

  function isReadCmd;
    input [7:0] cmd;
    begin
      isReadCmd = (cmd[7:4] == `ADS_CMD_READ_NIB);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // receive shifter
  localparam ST_IDLE = 2'd0;
  localparam ST_CMD = 2'd1;
  localparam ST_DATA = 2'd2;
  localparam ST_DONE = 2'd3;

  reg [1:0] state_reg;
  reg [4:0] bitCnt_reg;
  reg [23:0] shift_reg;
  reg [7:0] cmd_reg;
  reg [1:0] len_reg;
  reg [1:0] modeLatch_reg;
  reg [`ADS_FIFO_WIDTH-1:0] txShift_reg;
  reg [4:0] lastBit;
  wire [23:0] shiftNext;
  wire fifoValid;
  wire [`ADS_FIFO_WIDTH-1:0] fifoData;
  wire fifoPop;
  wire launchEdge;
  reg dacWrite_reg;
  reg [1:0] dacSel_reg;
  reg [DAC_W-1:0] dacWord_reg;

  assign shiftNext = {shift_reg[22:0], dinS};

  always @* begin
    case (len_reg)
      `ADS_LEN_24: lastBit = 5'd23;
      `ADS_LEN_16: lastBit = 5'd15;
      default: lastBit = 5'd7;
    endcase
  end

  // launch edge picked from the mode latched at transfer start
  assign launchEdge = (modeLatch_reg == `ADS_CKMODE_RISE) ? sclkRise : sclkFall;
  // a read pops its word on the ninth falling edge, bits leave on later launch edges
  assign fifoPop = (state_reg == ST_DATA) && isReadCmd(cmd_reg)
    && bitCnt_reg == 5'd8 && sclkFall;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      bitCnt_reg <= 5'd0;
      shift_reg <= 24'h000000;
      cmd_reg <= 8'h00;
      len_reg <= `ADS_LEN_8;
      modeLatch_reg <= 2'b00;
      clockMode <= 2'b00;
      txShift_reg <= {`ADS_FIFO_WIDTH{1'b0}};
      dout <= 1'b0;
      dacWrite_reg <= 1'b0;
      dacSel_reg <= 2'b00;
      dacWord_reg <= {DAC_W{1'b0}};
      started_reg <= 1'b0;
    end else begin
      dacWrite_reg <= 1'b0;
      if (!csLow) begin
        state_reg <= ST_IDLE;
        bitCnt_reg <= 5'd0;
        started_reg <= 1'b0;
      end else begin
        if (state_reg == ST_IDLE) begin
          state_reg <= ST_CMD;
          modeLatch_reg <= clockMode;
          len_reg <= `ADS_LEN_8;
        end
        if (sclkFall && state_reg != ST_DONE && state_reg != ST_IDLE) begin
          shift_reg <= shiftNext;
          bitCnt_reg <= bitCnt_reg + 5'd1;
          case (state_reg)
            ST_CMD: begin
              if (bitCnt_reg == 5'd7) begin
                cmd_reg <= shiftNext[7:0];
                len_reg <= cmdLength(shiftNext[7:0]);
                if (cmdLength(shiftNext[7:0]) == `ADS_LEN_8) begin
                  state_reg <= ST_DONE;
                  // new mode is latched at the start of the next transfer
                  if (isModeCmd(shiftNext[7:0])) begin
                    clockMode <= shiftNext[1:0];
                  end
                end else begin
                  state_reg <= ST_DATA;
                end
              end
            end
            ST_DATA: begin
              // a dac write commits only once the whole frame has arrived
              if (bitCnt_reg == lastBit) begin
                state_reg <= ST_DONE;
                if (isDacCmd(cmd_reg)) begin
                  dacWrite_reg <= 1'b1;
                  dacSel_reg <= cmd_reg[1:0];
                  dacWord_reg <= shiftNext[15:4];
                end
              end
            end
            default: state_reg <= state_reg;
          endcase
        end
        if (fifoPop) begin
          txShift_reg <= fifoValid ? fifoData : {`ADS_FIFO_WIDTH{1'b0}};
        end else if (launchEdge && started_reg) begin
          dout <= txShift_reg[`ADS_FIFO_WIDTH-1];
          txShift_reg <= {txShift_reg[`ADS_FIFO_WIDTH-2:0], 1'b0};
        end
        // nothing leaves dout until a read has loaded the shifter
        if (fifoPop) begin
          started_reg <= 1'b1;
        end
      end
    end
  end

  // enable trails the select pin by the synchroniser delay
  assign doutOeN = !csLow;

  ////////////////////////////////////////////////////////////////////////////
  // result buffer and conversion-done
  ads_fifo #(
    .WIDTH(`ADS_FIFO_WIDTH),
    .DEPTH(`ADS_FIFO_DEPTH),
    .AW(2)
  ) resultFifo (
    .clk(clk),
    .arst_n(arst_n),
    .inValid(resultValid),
    .inReady(resultReady),
    .inData(resultData),
    .outValid(fifoValid),
    .outReady(fifoPop),
    .outData(fifoData)
  );

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      eocN <= 1'b1;
    end else begin
      // low while a result waits in the buffer
      eocN <= !fifoValid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dac input and output registers
  // the strap is copied for three clocks, so the last copy sees the synchronised pin level
  reg [1:0] initCnt_reg;
  wire initDone;
  genvar g;

  assign initDone = (initCnt_reg == 2'b11);
  generate
    for (g = 0; g < NDAC; g = g + 1) begin : dacCh
      reg [DAC_W-1:0] inReg_reg;
      reg [DAC_W-1:0] outReg_reg;
      always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          inReg_reg <= `ADS_DAC_ZERO;
          outReg_reg <= `ADS_DAC_ZERO;
        end else if (!initDone) begin
          // strap copied for three clocks after reset release
          inReg_reg <= selSync_reg[1] ? `ADS_DAC_FULL : `ADS_DAC_ZERO;
          outReg_reg <= selSync_reg[1] ? `ADS_DAC_FULL : `ADS_DAC_ZERO;
        end else begin
          if (dacWrite_reg && dacSel_reg == g) begin
            inReg_reg <= dacWord_reg;
          end
          // output register tracks the input register while load is low
          if (loadLow) begin
            outReg_reg <= inReg_reg;
          end
        end
      end
      // transparent while load is low
      assign dacOut[g*DAC_W +: DAC_W] = loadLow ? inReg_reg : outReg_reg;
    end
  endgenerate

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      initCnt_reg <= 2'b00;
    end else if (!initDone) begin
      initCnt_reg <= initCnt_reg + 2'b01;
    end
  end
endmodule

// ==== testbench/ads_host_model.sv ====
// host master model driving the serial pins
`timescale 1ns/100ps
module ads_host_model (
  // serial pins
  input wire clk,
  output reg csN,
  output reg sclk,
  output reg din,
  input wire dout
);
  initial begin
    csN = 1'h1;
    sclk = 1'h0;
    din = 1'h0;
  end
  // sclk idles low, 4 clk a phase; dout taken 2 clk after each fall
  task automatic xfer(input int n, input [25:0] tx, output [25:0] rx);
    int i;
    begin
      rx = 26'h0;
      @(posedge clk);
      #1 csN = 1'h0;
      repeat (4) @(posedge clk);
      for (i = n - 1; i >= 0; i--) begin
        #1 din = tx[i];
        sclk = 1'h1;
        repeat (4) @(posedge clk);
        #1 sclk = 1'h0;
        repeat (2) @(posedge clk);
        rx[i] = dout;
        repeat (2) @(posedge clk);
      end
      repeat (8) @(posedge clk);
      #1 csN = 1'h1;
      din = ~din;
    end
  endtask
  // clocks and data with the select high, which the port must ignore
  task automatic stray(input int n);
    int i;
    begin
      for (i = 0; i < n; i++) begin
        @(posedge clk);
        #1 sclk = 1'h1;
        din = ~din;
        repeat (4) @(posedge clk);
        #1 sclk = 1'h0;
        repeat (3) @(posedge clk);
      end
    end
  endtask
endmodule

// ==== testbench/ads_serial_port_chk.sv ====
// assertions on the serial pin logic
`timescale 1ns/100ps
module ads_serial_port_chk #(
  parameter DAC_W = 12,
  parameter NDAC = 4
) (
  // watched ports
  input wire clk,
  input wire arst_n,
  input wire csN,
  input wire sclk,
  input wire dout,
  input wire doutOeN,
  input wire eocN,
  input wire dac_load_n,
  input wire [NDAC*DAC_W-1:0] dacOut,
  input wire resultValid,
  input wire resultReady,
  input wire [1:0] clockMode
);
  reg sclkReg;
  reg [3:0] fallAge;
  reg [3:0] riseAge;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // cycles since each serial clock edge was seen
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclkReg <= 1'h0;
      fallAge <= 4'hF;
      riseAge <= 4'hF;
    end else begin
      sclkReg <= sclk;
      fallAge <= (sclkReg && !sclk) ? 4'h0 : fallAge + {3'h0, fallAge != 4'hF};
      riseAge <= (!sclkReg && sclk) ? 4'h0 : riseAge + {3'h0, riseAge != 4'hF};
    end
  end
  AST_OE_IDLE: assert property (csN [*4] |-> doutOeN)
    else $error("dout enabled while deselected");
  AST_DOUT_QUIET: assert property (csN [*6] |-> dout == $past(dout))
    else $error("dout moved while deselected");
  AST_EOC_FALL: assert property (resultValid && resultReady |-> ##[1:3] !eocN)
    else $error("conversion-done late");
  AST_EOC_FULL: assert property (!resultReady |-> !eocN)
    else $error("full but conversion-done high");
  AST_LAUNCH_FALL: assert property (dout != $past(dout) && !doutOeN && !$past(doutOeN)
    && clockMode != 2'h3 |-> fallAge <= 4'h4)
    else $error("dout not launched on falling edge");
  AST_LAUNCH_RISE: assert property (dout != $past(dout) && !doutOeN && !$past(doutOeN)
    && clockMode == 2'h3 |-> riseAge <= 4'h4)
    else $error("dout not launched on rising edge");
  AST_MODE_IN_FRAME: assert property (clockMode != $past(clockMode) |-> !$past(csN, 3))
    else $error("clock mode changed outside a transfer");
  AST_DAC_HOLD: assert property (dac_load_n [*4] |-> dacOut == $past(dacOut))
    else $error("dac outputs moved while load high");
endmodule
bind ads_serial_port ads_serial_port_chk #(.DAC_W(DAC_W), .NDAC(NDAC)) chk (
  .clk(clk), .arst_n(arst_n), .csN(csN), .sclk(sclk), .dout(dout), .doutOeN(doutOeN),
  .eocN(eocN), .dac_load_n(dac_load_n), .dacOut(dacOut), .resultValid(resultValid),
  .resultReady(resultReady), .clockMode(clockMode));

// ==== testbench/tb_ads_serial_port.sv ====
// self-checking bench for the serial pin logic
`timescale 1ns/100ps
module tb_ads_serial_port;
  reg clk = 1'h0;
  reg arst_n = 1'h0;
  reg dacLoadN = 1'h0;
  reg strap = 1'h1;
  reg resultValid = 1'h0;
  reg [15:0] resultData = 16'h0;
  wire csN, sclk, din, dout, doutOeN, eocN, resultReady;
  wire [47:0] dacOut;
  wire [1:0] clockMode;
  reg [25:0] rx;
  int miscompares = 0;
  int compares = 0;
  always #25 clk = ~clk;
  ads_serial_port dut (
    .clk(clk), .arst_n(arst_n), .csN(csN), .sclk(sclk), .din(din), .dout(dout),
    .doutOeN(doutOeN), .eocN(eocN), .dac_load_n(dacLoadN), .dac_powerup_select(strap),
    .dacOut(dacOut), .resultValid(resultValid), .resultReady(resultReady),
    .resultData(resultData), .clockMode(clockMode));
  ads_host_model host (.clk(clk), .csN(csN), .sclk(sclk), .din(din), .dout(dout));
  ////////////////////////////////////////
  function automatic [15:0] word(input int k);
    word = 16'hA5C3 + k * 16'h1357;
  endfunction
  task automatic check(input [47:0] seen, input [47:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic resetDut(input s);
    @(posedge clk);
    #1 arst_n = 1'h0;
    strap = s;
    repeat (20) @(posedge clk);
    #1 arst_n = 1'h1;
    repeat (8) @(posedge clk);
    check(dacOut, s ? {4{12'hFFF}} : 48'h0, "dacPowerUp");
    $display("test reset done");
  endtask
  // stray clocks and a partial frame first: a leftover bit would misalign the full write
  task automatic dacTest;
    #1 dacLoadN = 1'h1;
    host.stray(4);
    host.xfer(12, 26'h125, rx);
    host.xfer(24, {8'h12, 12'h5A3, 4'h0}, rx);
    check(dacOut, 48'h0, "dacHeld");
    dacLoadN = 1'h0;
    repeat (6) @(posedge clk);
    check(dacOut, {12'h0, 12'h5A3, 24'h0}, "dacLoaded");
    $display("test dac done");
  endtask
  task automatic fifoTest;
    int k;
    for (k = 0; k < 5; k++) begin
      @(posedge clk);
      #1 resultValid = 1'h1;
      resultData = word(k);
      check(resultReady, k < 4, "resultReady");
      @(posedge clk);
      #1 resultValid = 1'h0;
    end
    repeat (3) @(posedge clk);
    check(eocN, 0, "eocLow");
    for (k = 0; k < 4; k++) begin
      host.xfer(8, {4'h2, 2'h0, k[1:0]}, rx);
      host.xfer(26, {8'h30, 18'h0}, rx);
      check(clockMode, k, "clockMode");
      repeat (3) @(posedge clk);
      check(doutOeN, 1, "doutOeN");
      check(k == 3 ? rx[16:1] : rx[15:0], word(k), "read");
    end
    repeat (4) @(posedge clk);
    check(eocN, 1, "eocEmpty");
    $display("test fifo done");
  endtask
  initial begin
    #1000000;
    miscompares++;
    results;
  end
  initial begin
    resetDut(1'h1);
    resetDut(1'h0);
    dacTest;
    fifoTest;
    results;
  end
endmodule
